/* File: design/dws_pkg.sv */
package dws_pkg;

	// ********************************************************
	// timing
	// ********************************************************
	localparam int unsigned CLK_HZ = 40_000_000;
	localparam int unsigned POWER_RATE_PPS = 160;
	// cycles between two power pulses, used as the top parameter default
	localparam int unsigned POWER_PERIOD_CYC = CLK_HZ / POWER_RATE_PPS;
	localparam int unsigned POWER_CNT_W = 18;

	// ********************************************************
	// memory geometry
	// ********************************************************
	localparam int unsigned SLOT_COUNT = 14;
	localparam int unsigned SLOT_W = 4;
	localparam int unsigned BIT_COUNT = 6;
	// bit-line positions by digit weight
	localparam int unsigned BIT_W1 = 0;
	localparam int unsigned BIT_W2 = 1;
	localparam int unsigned BIT_W4 = 2;
	localparam int unsigned BIT_W6 = 3;
	localparam int unsigned BIT_W8 = 4;
	localparam int unsigned BIT_W0 = 5;
	localparam int unsigned WORD_W = SLOT_W + BIT_COUNT;
	localparam int unsigned BUF_DEPTH = 2;

	// ********************************************************
	// values after reset or seizure
	// ********************************************************
	// pointer rests on the last slot so the first advance lands on slot one
	localparam logic [SLOT_W-1:0] SLOT_REST = 4'hd;
	localparam logic [SLOT_W-1:0] SLOT_LAST = 4'hd;
	localparam logic [SLOT_W-1:0] SLOT_FIRST = 4'h0;
	localparam logic STAGE_A_INIT = 1'b1;
	localparam logic STAGE_B_INIT = 1'b0;
	localparam logic ENABLE_INIT = 1'b1;
	localparam logic ARM_INIT = 1'b0;
	localparam logic ADV_SEL_INIT = 1'b0;

	typedef enum logic [1:0] {
		DWS_IDLE = 2'b00,
		DWS_ARMED = 2'b01,
		DWS_HELD = 2'b10
	} dws_wr_state_t;

endpackage

/* File: design/dws_power_gen.sv */
`timescale 1ns/10ps
module dws_power_gen #(
	parameter int unsigned PERIOD = dws_pkg::POWER_PERIOD_CYC
) (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic seize_i,
	output logic power_pulse_o
);
	import dws_pkg::*;

	logic [POWER_CNT_W-1:0] cnt_r;
	localparam logic [POWER_CNT_W-1:0] CNT_TOP = POWER_CNT_W'(PERIOD - 1);

	// ********************************************************
	// gated pulse timer
	// ********************************************************
	// counter only runs while seized; a pulse lasts one cycle, so a pulse
	// already begun is always finished before seize can take effect
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cnt_r <= '0;
		end else if (!seize_i) begin
			cnt_r <= '0;
		end else if (cnt_r == CNT_TOP) begin
			cnt_r <= '0;
		end else begin
			cnt_r <= cnt_r + 1'b1;
		end
	end

	// strobe registered so it never glitches
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			power_pulse_o <= 1'b0;
		end else begin
			power_pulse_o <= seize_i && (cnt_r == CNT_TOP);
		end
	end

endmodule

/* File: design/dws_buf2.sv */
`timescale 1ns/10ps
module dws_buf2 #(
	parameter int unsigned WIDTH = dws_pkg::WORD_W,
	parameter int unsigned DEPTH = dws_pkg::BUF_DEPTH
) (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic flush_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o
);
	localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int unsigned CW = $clog2(DEPTH + 1);

	logic [WIDTH-1:0] store_r [DEPTH];
	logic [PW-1:0] wptr_r;
	logic [PW-1:0] rptr_r;
	logic [CW-1:0] count_r;
	logic push;
	logic pop;

	// ********************************************************
	// handshakes
	// ********************************************************
	assign in_ready_o = (count_r != CW'(DEPTH));
	assign out_valid_o = (count_r != '0);
	assign push = in_valid_i && in_ready_o;
	assign pop = out_valid_o && out_ready_i;
	assign out_data_o = store_r[rptr_r];

	function automatic logic [PW-1:0] ptr_step(input logic [PW-1:0] p);
		ptr_step = (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
	endfunction

	// pointers and occupancy
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			wptr_r <= '0;
			rptr_r <= '0;
			count_r <= '0;
		end else if (flush_i) begin
			wptr_r <= '0;
			rptr_r <= '0;
			count_r <= '0;
		end else begin
			if (push) begin
				wptr_r <= ptr_step(wptr_r);
			end
			if (pop) begin
				rptr_r <= ptr_step(rptr_r);
			end
			if (push && !pop) begin
				count_r <= count_r + 1'b1;
			end else if (pop && !push) begin
				count_r <= count_r - 1'b1;
			end
		end
	end

	// storage needs no reset, occupancy guards it
	always_ff @(posedge clk_i) begin
		if (push) begin
			store_r[wptr_r] <= in_data_i;
		end
	end

endmodule

/* File: design/dws_top.sv */
// Function
// - pulses only while seized, finish begun pulse
// - seizure loads fixed initial pattern everywhere except the read code and the advance, notify and word select strobes
// - power pulses alternate phase A, phase B
// - first pulse after reset is phase A
// - steered A arms, next B fires write
// - one pointer advance per digit only
// - A after steer release re-enables digit
// - advances alternate between two outputs
// - every write event emits notification pulse
// - ring rests before slot one, steps
// - fourteen slots, pointer wraps, overwrites even unread
// - advance needs digit, A then B
// - cell written on word and bit
// - nine stored as weights one and eight
// - every phase A gives scan tick
// - pulse rate nominally 160 per second
`timescale 1ns/10ps
module dws_top #(
	parameter int unsigned POWER_PERIOD = dws_pkg::POWER_PERIOD_CYC
) (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic seize_i,
	input wire logic steer_line_i,
	input wire logic [dws_pkg::BIT_COUNT-1:0] bit_line_i,
	input wire logic rd_strobe_i,
	input wire logic [dws_pkg::SLOT_W-1:0] rd_slot_i,
	input wire logic out_ready_i,
	output logic power_pulse_o,
	output logic phase_a_pulse_o,
	output logic phase_b_pulse_o,
	output logic scan_tick_o,
	output logic bit_drive_o,
	output logic advance_first_o,
	output logic advance_second_o,
	output logic write_notify_o,
	output logic [dws_pkg::SLOT_COUNT-1:0] word_select_o,
	output logic [dws_pkg::SLOT_W-1:0] write_slot_o,
	output logic digit_enable_o,
	output logic [dws_pkg::BIT_COUNT-1:0] rd_code_o,
	output logic out_valid_o,
	output logic [dws_pkg::WORD_W-1:0] out_data_o
);
	import dws_pkg::*;

	// ********************************************************
	// declarations
	// ********************************************************
	logic seize_q_r;
	logic seize_rise;
	logic power_pulse;
	logic distributor_stage_a_r;
	logic distributor_stage_b_r;
	logic phase_a_pulse_r;
	logic phase_b_pulse_r;
	logic digit_enable_latch_r;
	logic write_arm_latch_r;
	logic adv_sel_r;
	logic [SLOT_W-1:0] slot_r;
	logic [SLOT_W-1:0] slot_nxt;
	logic write_fire;
	logic advance;
	logic buf_ready;
	logic [WORD_W-1:0] buf_word;
	logic [BIT_COUNT-1:0] mem_r [SLOT_COUNT];
	// status view of the two write latches, not a separate machine
	dws_wr_state_t wr_state;

	// ********************************************************
	// helpers
	// ********************************************************
	// ring step with wrap past the fourteenth slot
	function automatic logic [SLOT_W-1:0] ring_step(input logic [SLOT_W-1:0] s);
		ring_step = (s == SLOT_LAST) ? SLOT_FIRST : s + 1'b1;
	endfunction

	// one-hot word select line for a slot
	// only ever called with a slot in range, so no bit is lost
	function automatic logic [SLOT_COUNT-1:0] slot_onehot(input logic [SLOT_W-1:0] s);
		slot_onehot = '0;
		slot_onehot[s] = 1'b1;
	endfunction

	// slots fourteen and fifteen do not exist; reads there see nothing
	// and must never clear a real slot by aliasing
	function automatic logic slot_in_range(input logic [SLOT_W-1:0] s);
		slot_in_range = (s <= SLOT_LAST);
	endfunction

	// ********************************************************
	// seizure detection
	// ********************************************************
	// the rising edge of seize plays the converter reset pulse
	// a level reset would hold the cores cleared for the whole call,
	// so only the first cycle of a seizure loads the pattern
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			seize_q_r <= 1'b0;
		end else begin
			seize_q_r <= seize_i;
		end
	end

	assign seize_rise = seize_i && !seize_q_r;

	// ********************************************************
	// gated pulse generator
	// ********************************************************
	// counter starts from zero at each seizure, so the first power pulse
	// comes a full period after seizure, well after the reset pattern
	// the period parameter sets the nominal pulse rate; a short period
	// only speeds simulation, the sequencing does not depend on it
	dws_power_gen #(
		.PERIOD(POWER_PERIOD)
	) u_power (
		.clk_i(clk_i),
		.rst_b_i(rst_b_i),
		.seize_i(seize_i),
		.power_pulse_o(power_pulse)
	);

	assign power_pulse_o = power_pulse;

	// ********************************************************
	// two-phase distributor
	// ********************************************************
	// stage_a set means the next power pulse goes out as phase A;
	// the two stages always swap, so the phases never stall
	// a seizure edge wins over a coincident power pulse, so the first
	// phase after any seizure is always A
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			distributor_stage_a_r <= STAGE_A_INIT;
			distributor_stage_b_r <= STAGE_B_INIT;
		end else if (seize_rise) begin
			distributor_stage_a_r <= STAGE_A_INIT;
			distributor_stage_b_r <= STAGE_B_INIT;
		end else if (power_pulse) begin
			distributor_stage_a_r <= distributor_stage_b_r;
			distributor_stage_b_r <= distributor_stage_a_r;
		end
	end

	// phase strobes, one clock each
	// cleared on seizure so a strobe from the last call cannot arm the new one
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			phase_a_pulse_r <= 1'b0;
			phase_b_pulse_r <= 1'b0;
		end else if (seize_rise) begin
			phase_a_pulse_r <= 1'b0;
			phase_b_pulse_r <= 1'b0;
		end else begin
			phase_a_pulse_r <= power_pulse && distributor_stage_a_r;
			phase_b_pulse_r <= power_pulse && distributor_stage_b_r;
		end
	end

	assign phase_a_pulse_o = phase_a_pulse_r;
	assign phase_b_pulse_o = phase_b_pulse_r;
	// read control gets every phase A, whatever the write side does
	assign scan_tick_o = phase_a_pulse_r;
	// bit current only flows in phase B
	assign bit_drive_o = phase_b_pulse_r;

	// ********************************************************
	// write control
	// ********************************************************
	// a write fires on phase B only when a steered phase A armed it;
	// a full buffer skips that B, and a key still held re-arms on the next A
	// trade-off: a stalled consumer delays the digit rather than losing it,
	// but a key let go during the stall is dropped, never stored empty
	assign write_fire = phase_b_pulse_r && write_arm_latch_r && buf_ready;
	// advance only once per digit, gated by the enable latch
	assign advance = write_fire && digit_enable_latch_r;

	// arm latch
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			write_arm_latch_r <= ARM_INIT;
		end else if (seize_rise) begin
			write_arm_latch_r <= ARM_INIT;
		end else if (phase_a_pulse_r && steer_line_i) begin
			write_arm_latch_r <= 1'b1;
		end else if (phase_b_pulse_r) begin
			// every phase B disarms; a deferred write re-arms on the next steered A
			write_arm_latch_r <= 1'b0;
		end
	end

	// per-digit enable latch
	// holding steer keeps it clear, so repeated A/B pairs give no advance
	// a steered A must not re-enable, or a held key would advance twice
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			digit_enable_latch_r <= ENABLE_INIT;
		end else if (seize_rise) begin
			digit_enable_latch_r <= ENABLE_INIT;
		end else if (phase_a_pulse_r && !steer_line_i) begin
			digit_enable_latch_r <= 1'b1;
		end else if (write_fire) begin
			digit_enable_latch_r <= 1'b0;
		end
	end

	assign digit_enable_o = digit_enable_latch_r;

	// advance output selector toggles once per digit
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			adv_sel_r <= ADV_SEL_INIT;
		end else if (seize_rise) begin
			adv_sel_r <= ADV_SEL_INIT;
		end else if (advance) begin
			adv_sel_r <= !adv_sel_r;
		end
	end

	// write-side status for observation
	// held means a digit was taken and the key is still down
	always_comb begin
		if (write_arm_latch_r) begin
			wr_state = DWS_ARMED;
		end else if (!digit_enable_latch_r) begin
			wr_state = DWS_HELD;
		end else begin
			wr_state = DWS_IDLE;
		end
	end

	// advance and notify strobes, registered one cycle after the fire
	// notify follows every fire, even a repeat under a held key, so the
	// outside control can count them; the advance is once per digit
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			advance_first_o <= 1'b0;
			advance_second_o <= 1'b0;
			write_notify_o <= 1'b0;
		end else begin
			advance_first_o <= advance && !adv_sel_r;
			advance_second_o <= advance && adv_sel_r;
			write_notify_o <= write_fire && (wr_state == DWS_ARMED);
		end
	end

	// ********************************************************
	// write pointer ring
	// ********************************************************
	// after wrap the pointer reuses slots; nothing stops it overwriting
	// a digit not yet read, the read side must keep up
	assign slot_nxt = ring_step(slot_r);

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			slot_r <= SLOT_REST;
		end else if (seize_rise) begin
			slot_r <= SLOT_REST;
		end else if (advance) begin
			slot_r <= slot_nxt;
		end
	end

	assign write_slot_o = slot_r;

	// word select stands for one cycle, aligned with the advance strobes
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			word_select_o <= '0;
		end else if (advance) begin
			word_select_o <= slot_onehot(slot_nxt);
		end else begin
			word_select_o <= '0;
		end
	end

	// ********************************************************
	// coincident memory
	// ********************************************************
	// a word select alone never writes; the advance happens in phase B,
	// the only time the bit lines carry current, so word and bit meet.
	// both bits of a two-bit code, such as nine, land in the same cycle
	// a read and a write to one slot in one cycle keep the new digit
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			for (int i = 0; i < SLOT_COUNT; i++) begin
				mem_r[i] <= '0;
			end
		end else if (seize_rise) begin
			for (int i = 0; i < SLOT_COUNT; i++) begin
				mem_r[i] <= '0;
			end
		end else begin
			if (rd_strobe_i && slot_in_range(rd_slot_i)) begin
				mem_r[rd_slot_i] <= '0;
			end
			// a write after wrap reuses its slot whether or not a read has freed it
			if (advance && phase_b_pulse_r) begin
				mem_r[slot_nxt] <= bit_line_i;
			end
		end
	end

	// destructive read-out, like resetting the cores
	// a strobe on a missing slot returns an empty code rather than holding
	// the last one, so a stale digit is never read twice
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rd_code_o <= '0;
		end else if (rd_strobe_i && slot_in_range(rd_slot_i)) begin
			rd_code_o <= mem_r[rd_slot_i];
		end else if (rd_strobe_i) begin
			rd_code_o <= '0;
		end
	end

	// ********************************************************
	// stored-word buffer
	// ********************************************************
	// each stored digit is also queued with its slot so a stalled
	// consumer loses nothing; fullness holds back the write itself
	// flushed on seizure together with the memory
	assign buf_word = {slot_nxt, bit_line_i};

	dws_buf2 #(
		.WIDTH(WORD_W),
		.DEPTH(BUF_DEPTH)
	) u_buf (
		.clk_i(clk_i),
		.rst_b_i(rst_b_i),
		.flush_i(seize_rise),
		.in_valid_i(advance),
		.in_ready_o(buf_ready),
		.in_data_i(buf_word),
		.out_valid_o(out_valid_o),
		.out_ready_i(out_ready_i),
		.out_data_o(out_data_o)
	);

endmodule

/* File: tb/dws_receiver_model.sv */
`timescale 1ns/10ps
module dws_receiver_model (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic key_press_i,
	input wire logic [3:0] key_digit_i,
	output logic steer_line_o,
	output logic [dws_pkg::BIT_COUNT-1:0] bit_line_o
);
	import dws_pkg::*;
	logic high_group_key_relay;
	logic low_group_key_relay;
	logic both;
	// relays follow the key a clock later, so steering never leads the bit code
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			high_group_key_relay <= 1'b0;
			low_group_key_relay <= 1'b0;
		end else begin
			high_group_key_relay <= key_press_i;
			low_group_key_relay <= key_press_i;
		end
	end
	// steering closes only through one relay of each group
	assign both = high_group_key_relay & low_group_key_relay;
	assign steer_line_o = both;
	// one-of-ten closure onto one or two of six lines; open contacts carry no current
	always_comb begin
		bit_line_o = '0;
		bit_line_o[BIT_W1] = both & key_digit_i[0];
		bit_line_o[BIT_W2] = both & (key_digit_i[3:1] == 3'h1);
		bit_line_o[BIT_W4] = both & (key_digit_i[3:1] == 3'h2);
		bit_line_o[BIT_W6] = both & (key_digit_i[3:1] == 3'h3);
		bit_line_o[BIT_W8] = both & (key_digit_i[3:1] == 3'h4);
		bit_line_o[BIT_W0] = both & (key_digit_i == 4'h0);
	end
endmodule

/* File: tb/dws_top_sva.sv */
`timescale 1ns/10ps
module dws_top_sva (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic seize_i,
	input wire logic steer_line_i,
	input wire logic power_pulse_o,
	input wire logic phase_a_pulse_o,
	input wire logic phase_b_pulse_o,
	input wire logic scan_tick_o,
	input wire logic bit_drive_o,
	input wire logic advance_first_o,
	input wire logic advance_second_o,
	input wire logic write_notify_o,
	input wire logic [dws_pkg::SLOT_COUNT-1:0] word_select_o,
	input wire logic [dws_pkg::SLOT_W-1:0] write_slot_o,
	input wire logic digit_enable_o
);
	import dws_pkg::*;
	logic seize_d_r;
	logic last_a_r;
	logic sel_r;
	logic adv;
	assign adv = advance_first_o | advance_second_o;
	// last phase seen and next advance side; a seizure edge restarts both
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			seize_d_r <= 1'b0;
			last_a_r <= 1'b0;
			sel_r <= 1'b0;
		end else begin
			seize_d_r <= seize_i;
			if (seize_i && !seize_d_r) begin
				last_a_r <= 1'b0;
				sel_r <= 1'b0;
			end else begin
				if (phase_a_pulse_o)
					last_a_r <= 1'b1;
				if (phase_b_pulse_o)
					last_a_r <= 1'b0;
				if (adv)
					sel_r <= ~sel_r;
			end
		end
	end
	// ****
	// properties
	// ****
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);
	pwr_gate_a: assert property (power_pulse_o |-> $past(seize_i)) else $error("pulse unseized");
	pwr_single_a: assert property (power_pulse_o |=> !power_pulse_o) else $error("long pulse");
	phase_split_a: assert property ($past(power_pulse_o) == (phase_a_pulse_o | phase_b_pulse_o)
		&& !(phase_a_pulse_o && phase_b_pulse_o)) else $error("phase split");
	phase_order_a: assert property ((phase_a_pulse_o |-> !last_a_r) and (phase_b_pulse_o |-> last_a_r))
		else $error("phase order");
	tap_copy_a: assert property (scan_tick_o == phase_a_pulse_o && bit_drive_o == phase_b_pulse_o)
		else $error("tick copy");
	seize_init_a: assert property (seize_i && !seize_d_r |=> write_slot_o == SLOT_REST && digit_enable_o)
		else $error("seize pattern");
	adv_cause_a: assert property (adv |-> $past(phase_b_pulse_o) && write_notify_o && $past(digit_enable_o)
		&& !digit_enable_o) else $error("advance cause");
	notify_b_a: assert property (write_notify_o |-> $past(phase_b_pulse_o)) else $error("notify");
	adv_side_a: assert property ((advance_first_o |-> !sel_r) and (advance_second_o |-> sel_r))
		else $error("advance side");
	slot_step_a: assert property (adv |-> write_slot_o == ($past(write_slot_o) == SLOT_LAST ? SLOT_FIRST
		: $past(write_slot_o) + 4'h1)) else $error("slot step");
	word_hot_a: assert property (word_select_o == (adv ? 14'h1 << write_slot_o : 14'h0))
		else $error("word select");
	enable_back_a: assert property (phase_a_pulse_o && !steer_line_i |=> digit_enable_o)
		else $error("enable");
	cover property (advance_second_o);
	cover property (write_notify_o && !adv);
	cover property (adv && write_slot_o == SLOT_LAST);
endmodule
bind dws_top dws_top_sva u_sva (.clk_i, .rst_b_i, .seize_i, .steer_line_i, .power_pulse_o, .phase_a_pulse_o,
	.phase_b_pulse_o, .scan_tick_o, .bit_drive_o, .advance_first_o, .advance_second_o, .write_notify_o,
	.word_select_o, .write_slot_o, .digit_enable_o);

/* File: tb/tb_digit_write_sequencer.sv */
`timescale 1ns/10ps
module tb_digit_write_sequencer;
	import dws_pkg::*;
	// short period keeps each digit to a few dozen cycles
	localparam int PER = 8;
	logic clk_i, rst_b_i, seize_i, steer_line_i, rd_strobe_i, out_ready_i, key_press;
	logic power_pulse_o, phase_a_pulse_o, phase_b_pulse_o, scan_tick_o, bit_drive_o;
	logic advance_first_o, advance_second_o, write_notify_o, digit_enable_o, out_valid_o;
	logic [BIT_COUNT-1:0] bit_line_i, rd_code_o;
	logic [SLOT_W-1:0] rd_slot_i, write_slot_o;
	logic [SLOT_COUNT-1:0] word_select_o;
	logic [WORD_W-1:0] out_data_o;
	logic [3:0] key_digit;
	logic [5:0] code_of [10] = '{6'h20, 6'h01, 6'h02, 6'h03, 6'h04, 6'h05, 6'h08, 6'h09, 6'h10, 6'h11};
	int miscompares, comparisons, ndig;
	dws_top #(.POWER_PERIOD(PER)) uut (.clk_i, .rst_b_i, .seize_i, .steer_line_i, .bit_line_i, .rd_strobe_i,
		.rd_slot_i, .out_ready_i, .power_pulse_o, .phase_a_pulse_o, .phase_b_pulse_o, .scan_tick_o,
		.bit_drive_o, .advance_first_o, .advance_second_o, .write_notify_o, .word_select_o, .write_slot_o,
		.digit_enable_o, .rd_code_o, .out_valid_o, .out_data_o);
	dws_receiver_model rcv (.clk_i, .rst_b_i, .key_press_i(key_press), .key_digit_i(key_digit),
		.steer_line_o(steer_line_i), .bit_line_o(bit_line_i));
	initial begin
		clk_i = 1'b0;
		forever #12.5 clk_i = ~clk_i;
	end
	// ****
	// shared tasks
	// ****
	task automatic end_of_test();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic check(input logic ok, input string msg);
		comparisons++;
		if (ok !== 1'b1) begin
			miscompares++;
			$display("wrong value at %0t: %s", $time, msg);
		end
	endtask
	// bounded wait: 0 phase A, 2 advance, 3 power pulse
	task automatic wait_hi(input int which, input int lim);
		int i;
		logic hit;
		for (i = 0; i < lim; i++) begin
			@(negedge clk_i);
			hit = (which == 0) ? phase_a_pulse_o : (which == 2) ? (advance_first_o | advance_second_o) : power_pulse_o;
			if (hit === 1'b1)
				break;
		end
		if (i == lim) begin
			miscompares++;
			$display("wrong value at %0t: wait ran out", $time);
			end_of_test();
		end
	endtask
	// press a key until written, optionally hold it, read the slot back, let go
	task automatic enter_digit(input logic [3:0] d, input int hold);
		logic [3:0] slot;
		logic sec;
		int i, na, nn;
		slot = 4'(ndig % SLOT_COUNT);
		sec = ndig[0];
		na = 0;
		nn = 0;
		key_digit = d;
		key_press = 1'b1;
		wait_hi(2, 6 * PER);
		check(write_notify_o === 1'b1 && advance_second_o === sec && advance_first_o === !sec, "side");
		check(write_slot_o === slot && word_select_o === 14'h1 << slot, "slot");
		ndig++;
		for (i = 0; i < hold; i++) begin
			@(negedge clk_i);
			if ((advance_first_o | advance_second_o) !== 1'b0)
				na++;
			if (write_notify_o === 1'b1)
				nn++;
		end
		if (hold > 0)
			check(na == 0 && nn >= 2, "held key");
		rd_slot_i = slot;
		rd_strobe_i = 1'b1;
		@(negedge clk_i);
		rd_strobe_i = 1'b0;
		check(rd_code_o === code_of[d], "stored code");
		key_press = 1'b0;
		wait_hi(0, 3 * PER);
		@(negedge clk_i);
		check(digit_enable_o === 1'b1, "enable");
	endtask
	// ****
	// scenarios
	// ****
	task automatic t_idle();
		int i;
		check(write_slot_o === SLOT_REST && digit_enable_o === 1'b1, "reset pattern");
		for (i = 0; i < 3 * PER; i++) begin
			@(negedge clk_i);
			if (power_pulse_o !== 1'b0)
				check(1'b0, "idle pulse");
		end
	endtask
	task automatic t_seize();
		seize_i = 1'b1;
		wait_hi(3, PER + 3);
		@(negedge clk_i);
		check(phase_a_pulse_o === 1'b1 && scan_tick_o === 1'b1, "first phase");
		wait_hi(3, PER + 1);
		@(negedge clk_i);
		check(phase_b_pulse_o === 1'b1 && bit_drive_o === 1'b1, "second phase");
	endtask
	task automatic t_hold();
		enter_digit(4'h5, 6 * PER);
	endtask
	// consumer side stalls: two words fill the buffer, the third write waits
	task automatic t_stall();
		int i;
		out_ready_i = 1'b0;
		enter_digit(4'h9, 0);
		enter_digit(4'h1, 0);
		key_digit = 4'h2;
		key_press = 1'b1;
		for (i = 0; i < 4 * PER; i++) begin
			@(negedge clk_i);
			if ((advance_first_o | advance_second_o) !== 1'b0)
				check(1'b0, "write into full buffer");
		end
		check(out_valid_o === 1'b1 && out_data_o === {4'h1, 6'h11}, "buffer head");
		out_ready_i = 1'b1;
		enter_digit(4'h2, 0);
		repeat (4) @(negedge clk_i);
		check(out_valid_o === 1'b0, "buffer drained");
	endtask
	task automatic t_digits();
		while (ndig < SLOT_COUNT + 1)
			enter_digit(4'(ndig % 10), 0);
		// a slot past the fourteenth reads empty and drops the last code
		rd_slot_i = 4'he;
		rd_strobe_i = 1'b1;
		@(negedge clk_i);
		rd_strobe_i = 1'b0;
		check(rd_code_o === 6'h00, "slot past end");
	endtask
	task automatic t_release();
		int i;
		wait_hi(3, 2 * PER);
		seize_i = 1'b0;
		@(negedge clk_i);
		check(phase_a_pulse_o === 1'b1 || phase_b_pulse_o === 1'b1, "begun pulse");
		for (i = 0; i < 3 * PER; i++) begin
			@(negedge clk_i);
			if (power_pulse_o !== 1'b0)
				check(1'b0, "pulse released");
		end
		seize_i = 1'b1;
		ndig = 0;
		repeat (2) @(negedge clk_i);
		check(write_slot_o === SLOT_REST && digit_enable_o === 1'b1, "seize pattern");
		enter_digit(4'h7, 0);
	endtask
	initial begin
		rst_b_i = 1'b0;
		seize_i = 1'b0;
		key_press = 1'b0;
		key_digit = 4'h0;
		rd_strobe_i = 1'b0;
		rd_slot_i = 4'h0;
		out_ready_i = 1'b1;
		miscompares = 0;
		comparisons = 0;
		ndig = 0;
		repeat (16) @(negedge clk_i);
		rst_b_i = 1'b1;
		t_idle();
		t_seize();
		t_hold();
		t_stall();
		t_digits();
		t_release();
		end_of_test();
	end
endmodule
